/* File: src/adcrf_map.vh */
// register offsets, field positions and reset values of the result format and status block
`ifndef ADCRF_MAP_VH
`define ADCRF_MAP_VH
// -----------------------------------------------------------------
// register offsets (byte address = 4 * index)
// -----------------------------------------------------------------
`define ADCRF_IDX_STATUS 8'h06
`define ADCRF_IDX_TEST 8'h08
`define ADCRF_IDX_CTL2 8'h02
`define ADCRF_IDX_CTL3 8'h03
`define ADCRF_IDX_CTL4 8'h04
`define ADCRF_IDX_CTL5 8'h05
`define ADCRF_IDX_FMT 8'h10
`define ADCRF_IDX_RESULT 8'h11
// -----------------------------------------------------------------
// status field positions
// -----------------------------------------------------------------
`define ADCRF_SEQ_DONE_BIT 7
`define ADCRF_TRIG_OVR_BIT 5
`define ADCRF_RES_OVR_BIT 4
// -----------------------------------------------------------------
// format register field positions
// -----------------------------------------------------------------
`define ADCRF_FMT_RES8_BIT 0
`define ADCRF_FMT_RJUST_BIT 1
`define ADCRF_FMT_SIGNED_BIT 2
`define ADCRF_FMT_FFC_BIT 3
`define ADCRF_FMT_QUEUE_BIT 4
`define ADCRF_FMT_LEVEL_BIT 5
`define ADCRF_FMT_MULTI_CHANNEL_SEL_BIT 6
// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define ADCRF_FMT_RESET 8'h00
`define ADCRF_CHAN_RESET 3'h0
`define ADCRF_TEST_RESET 8'h00
`endif

/* File: src/adcrf_core.v */
// result formatting, channel select and status flags of an 8-channel converter
// Functional notes
// - 8-bit, left, unsigned: result in bits 15..8.
// - 8-bit, left, signed: two's complement result in bits 15..8.
// - 8-bit, right: unsigned in bits 7..0, sign select ignored.
// - 10-bit, left, unsigned: result in bits 15..6.
// - 10-bit, left, signed: two's complement result in bits 15..6.
// - 10-bit, right: unsigned in bits 9..0, sign select ignored.
// - signed code is unsigned code with its msb inverted.
// - channel code 0..7 selects analog input 0..7 in binary.
// - sequence done flag (bit 7) sets at end of every sequence.
// - done flag clears by write one, start write, or fast-clear result read.
// - edge mode: trigger during busy sequence sets trigger overrun (bit 5).
// - trigger overrun clears by write one, control 2/3/4 write, start write.
// - result write with complete flag still set sets result overrun (bit 4).
// - result overrun clears by write one, start write or edge-mode external trigger while idle.
// - status bits 2..0 show counter; status writes leave it unchanged.
// - queue off: counter zeroed at sequence start and end; queue on: kept at trigger start and sequence end.
// - counter wraps from seven to zero.
// - any write to control 2..5 clears the counter, even in queue mode.
// - test register reads unpredictable; writes only in special mode.
// - signed format is two's complement, never offered right justified.
// - multi-channel: each next conversion uses incremented code, wrapping.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "adcrf_map.vh"
module adcrf_core #(
   parameter RES_W = 10,
   parameter CNT_W = 3
) (
   input wire ref_clk,
   input wire rst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [9:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire special_mode,
   input wire seq_busy,
   input wire seq_end,
   input wire ext_trigger,
   input wire conv_done,
   input wire [RES_W-1:0] conv_raw,
   input wire [7:0] conversion_complete_flag,
   input wire [7:0] test_scramble,
   output reg [15:0] result_word,
   output reg result_write,
   output reg [CNT_W-1:0] conversion_counter,
   output reg [2:0] channel_select_code,
   output wire seq_start,
   output wire seq_abort,
   output wire result_read,
   output reg [7:0] test_reg_out
);
   // -----------------------------------------------------------------
   // bus decode
   // -----------------------------------------------------------------
   reg ack_r;
   reg [7:0] fmt_r;
   reg sequence_done_flag;
   reg trigger_overrun_flag;
   reg result_overrun_flag;
   reg [15:0] fmt_word;
   reg [2:0] code_nxt;
   wire req;
   wire wr;
   wire rd;
   wire lane0;
   wire [7:0] idx;
   wire wr_status;
   wire wr_ctl234;
   wire wr_ctl5;
   wire trig_start;
   wire fast_flag_clear;
   wire eight_bit_resolution_sel;
   wire right_justify_sel;
   wire signed_result_sel;
   wire queue_mode;
   wire trigger_level_edge_sel;
   wire multi_channel_sel;
   wire ccf_hit;

   // one wait state: ack follows a request one cycle later and drops the cycle after
   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;
   assign lane0 = wb_sel_i[0];
   assign idx = wb_adr_i[9:2];
   assign wb_ack_o = ack_r;
   assign wr_status = wr & lane0 & (idx == `ADCRF_IDX_STATUS);
   assign wr_ctl234 = wr & ((idx == `ADCRF_IDX_CTL2) | (idx == `ADCRF_IDX_CTL3) |
                            (idx == `ADCRF_IDX_CTL4));
   assign wr_ctl5 = wr & (idx == `ADCRF_IDX_CTL5);
   assign seq_start = wr_ctl5;
   assign seq_abort = wr_ctl234;
   assign result_read = rd & (idx == `ADCRF_IDX_RESULT);
   // of the external triggers, only an edge-mode one while idle starts a sequence
   assign trig_start = ext_trigger & ~trigger_level_edge_sel & ~seq_busy;

   assign eight_bit_resolution_sel = fmt_r[`ADCRF_FMT_RES8_BIT];
   assign right_justify_sel = fmt_r[`ADCRF_FMT_RJUST_BIT];
   assign signed_result_sel = fmt_r[`ADCRF_FMT_SIGNED_BIT];
   assign fast_flag_clear = fmt_r[`ADCRF_FMT_FFC_BIT];
   assign queue_mode = fmt_r[`ADCRF_FMT_QUEUE_BIT];
   assign trigger_level_edge_sel = fmt_r[`ADCRF_FMT_LEVEL_BIT];
   assign multi_channel_sel = fmt_r[`ADCRF_FMT_MULTI_CHANNEL_SEL_BIT];
   assign ccf_hit = conversion_complete_flag[conversion_counter];

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      end
   end

   // -----------------------------------------------------------------
   // control registers
   // -----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fmt_r <= `ADCRF_FMT_RESET;
         channel_select_code <= `ADCRF_CHAN_RESET;
         test_reg_out <= `ADCRF_TEST_RESET;
      end else begin
         if (wr & lane0 & (idx == `ADCRF_IDX_FMT)) begin
            fmt_r <= wb_dat_i[7:0];
         end
         if (wr_ctl5 & lane0) begin
            channel_select_code <= wb_dat_i[2:0];
         end else if (conv_done & multi_channel_sel) begin
            channel_select_code <= code_nxt;
         end
         // writes land only in special mode; normal mode acts unimplemented
         if (wr & lane0 & (idx == `ADCRF_IDX_TEST) & special_mode) begin
            test_reg_out <= wb_dat_i[7:0];
         end
      end
   end

   always @* begin
      code_nxt = channel_select_code + 3'h1;
   end

   // -----------------------------------------------------------------
   // result formatting
   // -----------------------------------------------------------------
   always @* begin
      fmt_word = 16'h0000;
      if (eight_bit_resolution_sel) begin
         if (right_justify_sel) begin
            fmt_word[7:0] = conv_raw[RES_W-1:RES_W-8];
         end else begin
            fmt_word[15:8] = conv_raw[RES_W-1:RES_W-8];
            fmt_word[15] = conv_raw[RES_W-1] ^ signed_result_sel;
         end
      end else begin
         if (right_justify_sel) begin
            fmt_word[9:0] = conv_raw[RES_W-1:RES_W-10];
         end else begin
            fmt_word[15:6] = conv_raw[RES_W-1:RES_W-10];
            fmt_word[15] = conv_raw[RES_W-1] ^ signed_result_sel;
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_word <= 16'h0000;
         result_write <= 1'b0;
      end else begin
         result_write <= conv_done;
         if (conv_done) begin
            result_word <= fmt_word;
         end
      end
   end

   // -----------------------------------------------------------------
   // status flags: hardware set wins over any clear in the same cycle
   // -----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sequence_done_flag <= 1'b0;
         trigger_overrun_flag <= 1'b0;
         result_overrun_flag <= 1'b0;
      end else begin
         if (seq_end) begin
            sequence_done_flag <= 1'b1;
         end else if ((wr_status & wb_dat_i[`ADCRF_SEQ_DONE_BIT]) | wr_ctl5 |
                      (result_read & fast_flag_clear)) begin
            sequence_done_flag <= 1'b0;
         end
         if (ext_trigger & ~trigger_level_edge_sel & seq_busy) begin
            trigger_overrun_flag <= 1'b1;
         end else if ((wr_status & wb_dat_i[`ADCRF_TRIG_OVR_BIT]) | wr_ctl234 | wr_ctl5) begin
            trigger_overrun_flag <= 1'b0;
         end
         if (conv_done & ccf_hit) begin
            result_overrun_flag <= 1'b1;
         end else if ((wr_status & wb_dat_i[`ADCRF_RES_OVR_BIT]) | wr_ctl5 | trig_start) begin
            result_overrun_flag <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // conversion counter
   // -----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         conversion_counter <= {CNT_W{1'b0}};
      end else begin
         if (wr_ctl234 | wr_ctl5) begin
            conversion_counter <= {CNT_W{1'b0}};
         end else if (~queue_mode & (seq_end | trig_start)) begin
            conversion_counter <= {CNT_W{1'b0}};
         end else if (conv_done) begin
            // natural overflow of the width gives the wrap
            conversion_counter <= conversion_counter + 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h00000000;
      end else if (rd) begin
         case (idx)
            `ADCRF_IDX_STATUS: wb_dat_o <= {24'h000000, sequence_done_flag, 1'b0,
                                           trigger_overrun_flag, result_overrun_flag, 1'b0,
                                           conversion_counter};
            // unpredictable content modelled by an input the bench drives
            `ADCRF_IDX_TEST: wb_dat_o <= {24'h000000, test_scramble};
            `ADCRF_IDX_FMT: wb_dat_o <= {24'h000000, fmt_r};
            `ADCRF_IDX_CTL5: wb_dat_o <= {29'h00000000, channel_select_code};
            `ADCRF_IDX_RESULT: wb_dat_o <= {16'h0000, result_word};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end
endmodule // adcrf_core

/* File: bench/adcrf_core_monitor.sv */
// assertion checker for the result format and status block
`timescale 1ns/1ps
`include "adcrf_map.vh"
module adcrf_core_monitor #(
   parameter RES_W = 10,
   parameter CNT_W = 3
) (
   input logic ref_clk,
   input logic rst_n,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [9:0] wb_adr_i,
   input logic [31:0] wb_dat_i,
   input logic wb_ack_o,
   input logic special_mode,
   input logic seq_busy,
   input logic seq_end,
   input logic ext_trigger,
   input logic conv_done,
   input logic result_write,
   input logic [CNT_W-1:0] conversion_counter,
   input logic [2:0] channel_select_code,
   input logic seq_start,
   input logic seq_abort,
   input logic result_read,
   input logic [7:0] test_reg_out
);
   // -----------------------------------------------------------------
   // bus and status relations
   // -----------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire [7:0] ix = wb_adr_i[9:2];
   a_ack_one_pulse: assert property (tk |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack is not a single pulse");
   a_start_decode: assert property (
      seq_start |-> tk && wb_we_i && ix == `ADCRF_IDX_CTL5) else $error("stray start");
   a_abort_decode: assert property (
      seq_abort |-> tk && wb_we_i && ix >= `ADCRF_IDX_CTL2 && ix <= `ADCRF_IDX_CTL4)
      else $error("stray abort");
   a_write_clears_count: assert property (
      (seq_start || seq_abort) && !conv_done |=> conversion_counter == 0)
      else $error("counter not cleared by control write");
   a_channel_load: assert property (
      seq_start |=> channel_select_code == $past(wb_dat_i[2:0])) else $error("channel code");
   a_result_pulse: assert property (result_write == $past(conv_done))
      else $error("result write pulse misplaced");
   a_count_wrap: assert property (
      seq_busy && conv_done && conversion_counter == 7 && !seq_start && !seq_abort
      |=> conversion_counter == 0) else $error("counter did not wrap");
   a_status_keeps_count: assert property (
      tk && wb_we_i && ix == `ADCRF_IDX_STATUS && !conv_done && !seq_end && !ext_trigger
      |=> $stable(conversion_counter)) else $error("status write moved counter");
   a_test_guard: assert property (
      tk && wb_we_i && ix == `ADCRF_IDX_TEST && !special_mode |=> $stable(test_reg_out))
      else $error("test register written outside special mode");
   a_read_decode: assert property (
      result_read |-> tk && !wb_we_i && ix == `ADCRF_IDX_RESULT) else $error("stray read");
   c_start: cover property (seq_start);
   c_abort: cover property (seq_abort);
   c_wrap: cover property (conv_done && conversion_counter == 7);
endmodule // adcrf_core_monitor
bind adcrf_core adcrf_core_monitor #(.RES_W(RES_W), .CNT_W(CNT_W)) mon_u (
   .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .special_mode(special_mode), .seq_busy(seq_busy), .seq_end(seq_end),
   .ext_trigger(ext_trigger), .conv_done(conv_done), .result_write(result_write),
   .conversion_counter(conversion_counter), .channel_select_code(channel_select_code),
   .seq_start(seq_start), .seq_abort(seq_abort), .result_read(result_read),
   .test_reg_out(test_reg_out));

/* File: bench/adcrf_core_tb.sv */
// self-checking bench for the result format and status block
`timescale 1ns/1ps
`include "adcrf_map.vh"
module adcrf_core_tb;
   logic ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, spm = 1'b0;
   logic busy = 1'b0, send = 1'b0, trig = 1'b0, cdone = 1'b0;
   logic [9:0] adr = 10'h000, raw = 10'h000;
   logic [31:0] wdat = 32'h0, q;
   logic [7:0] ccf = 8'h00;
   wire [31:0] rdat;
   wire ack, rwr, sst, sab, rrd;
   wire [15:0] rword;
   wire [2:0] cnt, chan;
   wire [7:0] tro;
   int errors = 0, n_compared = 0, cycles = 0, k = 0;
   // 0x2AA and 0x155 give the same 8-bit code whichever raw bits feed it
   logic [9:0] pat [2] = '{10'h2AA, 10'h155};
   adcrf_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .special_mode(spm), .seq_busy(busy), .seq_end(send),
      .ext_trigger(trig), .conv_done(cdone), .conv_raw(raw), .conversion_complete_flag(ccf),
      .test_scramble(8'hC3), .result_word(rword), .result_write(rwr),
      .conversion_counter(cnt), .channel_select_code(chan), .seq_start(sst),
      .seq_abort(sab), .result_read(rrd), .test_reg_out(tro));
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   initial forever #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         finish_test;
      end
   end
   function automatic logic [15:0] fmtx(input logic [2:0] f, input logic [9:0] r);
      case (f)
         3'h0: fmtx = {r, 6'h00};
         3'h4: fmtx = {~r[9], r[8:0], 6'h00};
         3'h2, 3'h6: fmtx = {6'h00, r};
         3'h1: fmtx = {r[9:2], 8'h00};
         3'h5: fmtx = {~r[9], r[8:2], 8'h00};
         default: fmtx = {8'h00, r[9:2]};
      endcase
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wb(input logic w, input logic [7:0] ix, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      wdat <= d;
      // ack and read data are sampled at the edge itself; only the bench timeout ends a wait
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task conv(input logic [9:0] r, input logic [7:0] fl);
      @(posedge ref_clk);
      cdone <= 1'b1;
      raw <= r;
      ccf <= fl;
      @(posedge ref_clk);
      cdone <= 1'b0;
      ccf <= 8'h00;
      #1;
   endtask
   task ev(input logic is_end);
      @(posedge ref_clk);
      send <= is_end;
      trig <= !is_end;
      @(posedge ref_clk);
      send <= 1'b0;
      trig <= 1'b0;
   endtask
   task finish_test;
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         wb(1'b1, `ADCRF_IDX_CTL5, c);
         chk(chan, c);
      end
      busy <= 1'b1;
      for (int f = 0; f < 8; f++) begin
         wb(1'b1, `ADCRF_IDX_FMT, f);
         for (int p = 0; p < 2; p++) begin
            conv(pat[p], 8'h00);
            k++;
            chk(rword, fmtx(f, pat[p]));
            chk(cnt, k % 8);
         end
      end
      wb(1'b0, `ADCRF_IDX_RESULT, 0);
      chk(q, 32'h0055);
      conv(10'h000, 8'hFF);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h11);
      wb(1'b1, `ADCRF_IDX_STATUS, 32'hFF);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h01);
      ev(1'b0);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h21);
      wb(1'b1, `ADCRF_IDX_CTL2, 0);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h00);
      conv(10'h000, 8'hFF);
      ev(1'b1);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h90);
      wb(1'b1, `ADCRF_IDX_CTL5, 3);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h00);
      ev(1'b1);
      wb(1'b1, `ADCRF_IDX_STATUS, 32'h80);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h00);
      wb(1'b1, `ADCRF_IDX_FMT, 32'h08);
      ev(1'b1);
      wb(1'b0, `ADCRF_IDX_RESULT, 0);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h00);
      wb(1'b1, `ADCRF_IDX_FMT, 32'h10);
      conv(10'h001, 8'h00);
      conv(10'h002, 8'h00);
      ev(1'b1);
      #1;
      chk(cnt, 2);
      wb(1'b1, `ADCRF_IDX_CTL4, 0);
      chk(cnt, 0);
      wb(1'b1, `ADCRF_IDX_TEST, 32'h5A);
      chk(tro, 8'h00);
      spm <= 1'b1;
      wb(1'b1, `ADCRF_IDX_TEST, 32'h5A);
      chk(tro, 8'h5A);
      wb(1'b0, `ADCRF_IDX_TEST, 0);
      chk(q, 32'hC3);
      wb(1'b0, 8'h3F, 0);
      chk(q, 32'h0);
      wb(1'b1, `ADCRF_IDX_FMT, 32'h40);
      wb(1'b1, `ADCRF_IDX_CTL5, 7);
      conv(10'h3FF, 8'h00);
      chk(chan, 0);
      chk(rwr, 1'b1);
      chk(rword, 16'hFFC0);
      conv(10'h000, 8'hFF);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h12);
      busy <= 1'b0;
      ev(1'b0);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h00);
      rst_n <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk(tro, 8'h00);
      wb(1'b0, `ADCRF_IDX_STATUS, 0);
      chk(q, 32'h00);
      finish_test;
   end
endmodule // adcrf_core_tb
